// [hub_cfg_pkg.sv]
// Constants, types and register layout of the hub configuration and port power loader
// What this block does
// - Ganged mode: all port power outputs switch together; any overcurrent powers every port off.
// - Individual mode: each port power output and overcurrent input works for its own port.
// - Overcurrent is signalled by driving its input low; low means overcurrent.
// - Four power modes: bus or self powered, combined with ganged or individual switching.
// - Bus or self powered operation follows the static bus power select level.
// - Clock select and fast clock input low: reference is a 6 MHz crystal.
// - Clock select and crystal input high: 48 MHz oscillator on fast clock input.
// - Memory select high: default identity, memory clock off, data pin is ganged input.
// - Memory select low: shared pins become memory clock and data for custom identifiers.
// - Pulldowns on memory clock and data on only while the memory interface is enabled.
// - Image is three words: ganged flag in word 0 bit 14, vendor, product.
// - After power-on reset with memory select low, exactly one read sequence is made.
// - Read starts with start bit 1, opcode 10, then word address 00000.
// - After the address the device releases the data line and the memory drives it.
// - After three words, memory clock and data are released to the pulldowns.
// - Each port picks its driver slew rate from the attached device speed.
package hub_cfg_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IDS_OFFSET = 8'h08;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Identity shown without a memory; both values are arbitrary
  localparam logic [15:0] DEFAULT_VENDOR_ID = 16'h0F0F;
  localparam logic [15:0] DEFAULT_PRODUCT_ID = 16'h0001;
  // Timing
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int EE_CLK_PERIOD_NS = 320;
  localparam int EE_HALF_CYCLES = (EE_CLK_PERIOD_NS / 2 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [2:0] HALF_LAST = 3'(EE_HALF_CYCLES - 1);
  localparam logic [1:0] SETTLE_LAST = 2'h3;
  // Read command and image layout
  localparam logic [7:0] CMD_WORD = 8'hC0;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] DATA_LAST = 6'h2F;
  localparam int GANGED_POS = 2 * 16 + 14;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_CMD = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } load_state_type;

  typedef enum logic [1:0] {
    CLK_MODE_NONE = 2'b00,
    CLK_MODE_CRYSTAL = 2'b01,
    CLK_MODE_OSC = 2'b10
  } clk_mode_type;

  typedef struct packed {
    logic fast_clk;
    logic xtal_in;
    logic clk_sel;
    logic ext_mem;
    logic bus_power;
  } strap_type;

  typedef struct packed {
    logic [17:0] zero;
    clk_mode_type clk_mode;
    logic ee_enabled;
    logic bus_powered;
    logic ganged;
    logic load_done;
    logic [3:0] oc;
    logic [3:0] power;
  } status_type;

  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] product;
  } ids_type;
endpackage

// [hub_config_power_loader.sv]
// Hub configuration loader, port power control and APB register slave
`timescale 1ns/100ps
`default_nettype none
module hub_config_power_loader (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps
  input wire logic bus_power_select,
  input wire logic external_memory_select,
  input wire logic clock_source_select,
  input wire logic fast_clock_input,
  input wire logic crystal_in,
  // Port power
  input wire logic [3:0] overcurrent_in,
  output logic [3:0] port_power_enable,
  // Port speed
  input wire logic [3:0] port_low_speed,
  output logic [3:0] port_slew_slow,
  // Serial memory
  output logic eeprom_serial_clock_out,
  output logic eeprom_serial_clock_oe,
  input wire logic eeprom_serial_io_in,
  output logic eeprom_serial_io_out,
  output logic eeprom_serial_io_oe,
  output logic eeprom_pulldown_enable
);
  import hub_cfg_pkg::*;

  localparam int LOAD_MAX = 470;

  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic [1:0] wait_reg;
  logic ext_strap_reg;
  load_state_type state_reg, state_next;
  logic [2:0] phase_reg;
  logic sclk_reg;
  logic [5:0] cnt_reg, cnt_next;
  logic [47:0] shift_reg, shift_next;
  logic io_out_reg, io_out_next;
  logic io_oe_reg, io_oe_next;
  logic clk_oe_reg, clk_oe_next;
  logic pulldown_reg;
  logic ganged_reg;
  ids_type ids_reg;
  logic [3:0] req_reg;
  logic [3:0] oc_flag_reg;
  logic [3:0] power_reg;
  logic [3:0] slew_reg;
  logic bus_pwr_reg;
  clk_mode_type clk_mode_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Synchronised pins
  strap_type strap_sync;
  wire logic io_sync;
  wire logic [3:0] oc_active;
  assign strap_sync = strap_type'(sync2_reg[4:0]);
  assign io_sync = sync2_reg[5];
  assign oc_active = ~sync2_reg[9:6];

  // Serial clock timing
  wire logic running = (state_reg == ST_CMD) || (state_reg == ST_DATA);
  wire logic phase_end = phase_reg == HALF_LAST;
  wire logic rise = running && phase_end && !sclk_reg;
  wire logic fall = running && phase_end && sclk_reg;
  wire logic settled = wait_reg == SETTLE_LAST;
  wire logic done = state_reg == ST_DONE;
  wire logic [47:0] shift_in = {shift_reg[46:0], io_sync};
  wire logic load_end = (state_reg == ST_DATA) && fall && (cnt_reg == DATA_LAST);

  // Ganged choice: image bit after a load, the shared data pin when the memory is strapped off
  wire logic ganged_next = load_end ? shift_in[GANGED_POS] :
    (done && ext_strap_reg) ? io_sync : ganged_reg;
  wire logic any_oc = |oc_flag_reg;
  wire logic [3:0] power_gang = {4{req_reg[0] && !any_oc}};
  wire logic [3:0] power_indiv = req_reg & ~oc_flag_reg;
  // Ports stay off until the power mode is known
  wire logic [3:0] power_next = !done ? 4'h0 : ganged_reg ? power_gang : power_indiv;

  // Clock source decode
  wire clk_mode_type clk_mode_next = clk_mode_type'((strap_sync.clk_sel && strap_sync.xtal_in) ? CLK_MODE_OSC :
    (!strap_sync.clk_sel && !strap_sync.fast_clk) ? CLK_MODE_CRYSTAL : CLK_MODE_NONE);

  // APB decode
  wire logic access = psel && penable;
  wire logic take = access && pready_reg;
  wire logic hit_ctrl = paddr == CTRL_OFFSET;
  wire logic hit_status = paddr == STATUS_OFFSET;
  wire logic hit_ids = paddr == IDS_OFFSET;
  wire logic hit = hit_ctrl || hit_status || hit_ids;
  wire logic wr_ctrl = take && pwrite && hit_ctrl;
  wire logic wr_status = take && pwrite && hit_status;
  wire logic pready_next = access && !pready_reg;
  status_type status_word;
  status_type status_wdata;
  assign status_wdata = status_type'(pwdata);
  assign status_word = '{zero: 18'h00000, clk_mode: clk_mode_reg, ee_enabled: !ext_strap_reg,
    bus_powered: bus_pwr_reg, ganged: ganged_reg, load_done: done, oc: oc_flag_reg, power: power_reg};
  wire logic [31:0] rdata = hit_ctrl ? {28'h0000000, req_reg} :
    hit_status ? 32'(status_word) : hit_ids ? 32'(ids_reg) : 32'h00000000;
  // Hardware set wins over a software clear in the same cycle
  wire logic [3:0] oc_clear = wr_status ? status_wdata.oc : 4'h0;
  wire logic [3:0] oc_flag_next = (oc_flag_reg & ~oc_clear) | oc_active;

  // Loader sequence
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    io_out_next = io_out_reg;
    io_oe_next = io_oe_reg;
    clk_oe_next = clk_oe_reg;
    case (state_reg)
      ST_WAIT: begin
        if (settled) begin
          if (!strap_sync.ext_mem) begin
            state_next = ST_CMD;
            shift_next = {CMD_WORD, 40'h0000000000};
            io_out_next = CMD_WORD[7];
            io_oe_next = 1'b1;
            clk_oe_next = 1'b1;
            cnt_next = 6'h00;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_CMD: begin
        if (rise) begin
          cnt_next = cnt_reg + 6'h01;
          shift_next = {shift_reg[46:0], 1'b0};
        end else if (fall) begin
          if (cnt_reg == CMD_BITS) begin
            // The dummy bit falls in this half period and is never sampled
            io_oe_next = 1'b0;
            state_next = ST_DATA;
            cnt_next = 6'h00;
          end else begin
            io_out_next = shift_reg[47];
          end
        end
      end
      ST_DATA: begin
        // Memory moves data on the rising edge, so sample at the falling one
        if (fall) begin
          shift_next = shift_in;
          cnt_next = cnt_reg + 6'h01;
          if (load_end) begin
            state_next = ST_DONE;
            clk_oe_next = 1'b0;
          end
        end
      end
      ST_DONE: begin
        io_oe_next = 1'b0;
        clk_oe_next = 1'b0;
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 10'h3C0;
      sync2_reg <= 10'h3C0;
    end else begin
      sync1_reg <= {overcurrent_in, eeprom_serial_io_in, fast_clock_input, crystal_in,
        clock_source_select, external_memory_select, bus_power_select};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 2'h0;
      ext_strap_reg <= 1'b1;
    end else begin
      if (!settled) begin
        wait_reg <= wait_reg + 2'h1;
      end
      // Strap taken once after release, so one load per reset
      if (state_reg == ST_WAIT && settled) begin
        ext_strap_reg <= strap_sync.ext_mem;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_WAIT;
      phase_reg <= 3'h0;
      sclk_reg <= 1'b0;
      cnt_reg <= 6'h00;
      shift_reg <= 48'h000000000000;
      io_out_reg <= 1'b0;
      io_oe_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= (running && !phase_end) ? phase_reg + 3'h1 : 3'h0;
      sclk_reg <= running && (phase_end ? !sclk_reg : sclk_reg);
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      io_out_reg <= io_out_next;
      io_oe_reg <= io_oe_next;
      clk_oe_reg <= clk_oe_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ids_reg <= '{vendor: DEFAULT_VENDOR_ID, product: DEFAULT_PRODUCT_ID};
      ganged_reg <= 1'b0;
      pulldown_reg <= 1'b0;
      bus_pwr_reg <= 1'b0;
      clk_mode_reg <= CLK_MODE_NONE;
      slew_reg <= 4'h0;
    end else begin
      if (load_end) begin
        ids_reg <= ids_type'(shift_in[31:0]);
      end
      ganged_reg <= ganged_next;
      pulldown_reg <= !ext_strap_reg;
      bus_pwr_reg <= strap_sync.bus_power;
      clk_mode_reg <= clk_mode_next;
      slew_reg <= port_low_speed;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= CTRL_RESET;
      oc_flag_reg <= 4'h0;
      power_reg <= 4'h0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        req_reg <= pwdata[3:0];
      end
      oc_flag_reg <= oc_flag_next;
      power_reg <= power_next;
      pready_reg <= pready_next;
      prdata_reg <= pready_next ? rdata : 32'h00000000;
      pslverr_reg <= pready_next && !hit;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign port_power_enable = power_reg;
  assign port_slew_slow = slew_reg;
  assign eeprom_serial_clock_out = sclk_reg;
  assign eeprom_serial_clock_oe = clk_oe_reg;
  assign eeprom_serial_io_out = io_out_reg;
  assign eeprom_serial_io_oe = io_oe_reg;
  assign eeprom_pulldown_enable = pulldown_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence load_start;
    $rose(state_reg == ST_CMD);
  endsequence
  sequence cmd_end;
    state_reg == ST_CMD && fall && cnt_reg == CMD_BITS;
  endsequence
  sequence load_finish;
    state_reg == ST_DATA && load_end;
  endsequence

  ganged_off_a: assert property (ganged_reg && any_oc |=> port_power_enable == 4'h0)
    else $error("ganged overcurrent left a port powered");
  port_off_a: assert property (!ganged_reg && oc_flag_reg[2] |=> !port_power_enable[2])
    else $error("individual overcurrent left its port powered");
  oc_low_a: assert property (!sync2_reg[7] |=> oc_flag_reg[1])
    else $error("low overcurrent input not flagged");
  bus_mode_a: assert property (##1 status_word.bus_powered == $past(strap_sync.bus_power))
    else $error("bus power status does not follow strap");
  clk_mode_a: assert property (strap_sync.clk_sel && strap_sync.xtal_in |=> clk_mode_reg == CLK_MODE_OSC)
    else $error("oscillator clock mode not reported");
  ext_high_a: assert property (done && ext_strap_reg |-> !eeprom_serial_clock_oe && ids_reg.product == DEFAULT_PRODUCT_ID)
    else $error("memory disabled but identity or clock changed");
  pulldown_a: assert property (##1 eeprom_pulldown_enable == !$past(ext_strap_reg))
    else $error("pulldown enable does not follow interface enable");
  load_once_a: assert property (load_start |-> ##[1:LOAD_MAX] done)
    else $error("load did not finish in time");
  cmd_bit_a: assert property (state_reg == ST_CMD && rise |-> io_oe_reg && io_out_reg == CMD_WORD[3'(7 - cnt_reg[2:0])])
    else $error("wrong command bit on data line");
  release_a: assert property (cmd_end |=> !io_oe_reg && state_reg == ST_DATA)
    else $error("data line not released after address");
  tristate_a: assert property (load_finish |=> done && !eeprom_serial_clock_oe && !eeprom_serial_io_oe)
    else $error("interface not released after three words");
  gang_src_a: assert property (load_finish |=> ganged_reg == $past(shift_in[GANGED_POS]))
    else $error("ganged choice not taken from word 0");
  slew_a: assert property (presetn |=> port_slew_slow == $past(port_low_speed))
    else $error("slew select does not follow port speed");
endmodule
`default_nettype wire

// [serial_memory_model.sv]
// Serial configuration memory on the far side of the loader
`timescale 1ns/100ps
`default_nettype none
module serial_memory_model #(
  parameter logic [47:0] IMAGE = 48'h0
) (
  // Link
  input wire logic sclk,
  input wire logic cs,
  input wire logic line,
  output logic q,
  output logic q_oe,
  // Observation
  output logic [7:0] cmd,
  output int rises
);
  logic [15:0] mem [0:63];
  int k;
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = (i < 3) ? IMAGE[47 - 16 * i -: 16] : 16'hFFFF;
    end
  end
  assign k = rises - 8;
  // Takes the line only after the loader lets go at the falling edge
  assign q_oe = cs && rises >= 8 && rises <= 56 && !(rises == 8 && sclk) && !(rises == 56 && !sclk);
  // Chip select is the power-on reset
  always @(posedge sclk or negedge cs) begin
    if (!cs) begin
      rises <= 0;
      q <= 1'b0;
      cmd <= 8'h00;
    end else begin
      rises <= rises + 1;
      if (rises < 8) begin
        cmd <= {cmd[6:0], line};
      end
      // Dummy zero, then three words msb first, address stepping itself
      if (rises == 7) begin
        q <= 1'b0;
      end else if (rises >= 8 && rises < 56) begin
        q <= mem[cmd[4:0] + 5'(k / 16)][15 - k % 16];
      end
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the hub configuration and port power loader
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hub_cfg_pkg::*;
  localparam logic [15:0] VEND = 16'hA55A;
  localparam logic [15:0] PROD = 16'h3CC3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic bus_sel = 1'b1, ext_sel = 1'b0, clk_sel = 1'b0, fast_clk = 1'b0, xtal = 1'b0, gang_pin = 1'b0;
  logic [3:0] oc_n = 4'hF;
  logic [3:0] low_spd = 4'h0;
  wire logic [31:0] prdata;
  wire logic [3:0] pwr, slew;
  wire logic pready, pslverr, clk_out, clk_oe, io_out, io_oe, pd_en, mem_q, mem_oe;
  wire logic [7:0] mem_cmd;
  int mem_rises;
  logic io_last = 1'b0;
  // Undriven data without pulldown flips so no stale level passes for data
  wire logic io_line = io_oe ? io_out : (mem_oe ? mem_q : (pd_en ? 1'b0 : ~io_last));
  // Undriven clock rests low: a floating edge would advance the memory before the load
  wire logic sclk = clk_oe ? clk_out : 1'b0;
  wire logic io_in = ext_sel ? gang_pin : io_line;
  int num_errors = 0, compares = 0, clash = 0, oe_cycles = 0, mark, i;
  logic [31:0] rd;
  logic err;

  always #20 pclk = ~pclk;

  hub_config_power_loader uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_power_select(bus_sel), .external_memory_select(ext_sel), .clock_source_select(clk_sel),
    .fast_clock_input(fast_clk), .crystal_in(xtal), .overcurrent_in(oc_n), .port_power_enable(pwr),
    .port_low_speed(low_spd), .port_slew_slow(slew), .eeprom_serial_clock_out(clk_out),
    .eeprom_serial_clock_oe(clk_oe), .eeprom_serial_io_in(io_in), .eeprom_serial_io_out(io_out),
    .eeprom_serial_io_oe(io_oe), .eeprom_pulldown_enable(pd_en));

  serial_memory_model #(.IMAGE({16'h4000, VEND, PROD})) mem (.sclk(sclk), .cs(presetn), .line(io_line),
    .q(mem_q), .q_oe(mem_oe), .cmd(mem_cmd), .rises(mem_rises));

  always @(posedge pclk) begin
    io_last <= io_line;
    if (io_oe === 1'b1 && mem_oe === 1'b1) clash <= clash + 1;
    if (clk_oe === 1'b1) oe_cycles <= oe_cycles + 1;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No time limit here: pready ends this wait, or the watchdog if it never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  function logic [31:0] stat(logic [3:0] pw, logic [3:0] fl, logic g, logic b, logic e, logic [1:0] m);
    return {18'h0, m, e, b, g, 1'b1, fl, pw};
  endfunction

  task conclude;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    num_errors++;
    conclude();
  end

  initial begin
    idle(20);
    presetn <= 1'b1;
    for (i = 0; i < 40; i++) begin
      apb(1'b0, STATUS_OFFSET, 32'h0);
      if (rd[8] === 1'b1) break;
      idle(20);
    end
    check(32'(mem_cmd), 32'hC0);
    check(32'(mem_rises), 32'd56);
    check({clk_oe, io_oe, pd_en}, 3'b001);
    rd_chk(IDS_OFFSET, {VEND, PROD});
    rd_chk(STATUS_OFFSET, stat(4'h0, 4'h0, 1'b1, 1'b1, 1'b1, 2'b01));
    apb(1'b1, CTRL_OFFSET, 32'h1);
    idle(2);
    check(pwr, 4'hF);
    oc_n <= 4'b1011;
    idle(5);
    check(pwr, 4'h0);
    oc_n <= 4'hF;
    rd_chk(STATUS_OFFSET, stat(4'h0, 4'b0100, 1'b1, 1'b1, 1'b1, 2'b01));
    apb(1'b1, STATUS_OFFSET, 32'h40);
    idle(2);
    check(pwr, 4'hF);
    low_spd <= 4'b0110;
    idle(2);
    check(slew, 4'b0110);
    low_spd <= 4'b1001;
    idle(2);
    check(slew, 4'b1001);
    rd_chk(8'h0C, 32'h0);
    check(err, 1'b1);
    idle(200);
    check(32'(mem_rises), 32'd56);
    check(clash, 0);
    // Second reset with the memory strapped off and the oscillator source
    mark = oe_cycles;
    presetn <= 1'b0;
    ext_sel <= 1'b1;
    bus_sel <= 1'b0;
    clk_sel <= 1'b1;
    xtal <= 1'b1;
    idle(20);
    presetn <= 1'b1;
    idle(30);
    rd_chk(IDS_OFFSET, {DEFAULT_VENDOR_ID, DEFAULT_PRODUCT_ID});
    rd_chk(STATUS_OFFSET, stat(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 2'b10));
    check(pd_en, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'hB);
    idle(2);
    check(pwr, 4'hB);
    oc_n <= 4'b1110;
    idle(5);
    check(pwr, 4'hA);
    oc_n <= 4'hF;
    gang_pin <= 1'b1;
    idle(5);
    check(pwr, 4'h0);
    apb(1'b1, STATUS_OFFSET, 32'hF0);
    idle(2);
    check(pwr, 4'hF);
    clk_sel <= 1'b0;
    fast_clk <= 1'b1;
    idle(5);
    rd_chk(STATUS_OFFSET, stat(4'hF, 4'h0, 1'b1, 1'b0, 1'b0, 2'b00));
    check(oe_cycles - mark, 0);
    conclude();
  end
endmodule
`default_nettype wire
